// [logic/flagged_fifo_pkg.sv]
// Functional notes
// - latch standard or fall-through mode at reset
// - fall-through flags allow direct chaining
// - empty/full or ready flags, plus three
// - thresholds programmable, counted from each boundary
// - eight default offset pairs chosen at reset
// - serial load shifts one bit per edge
// - parallel load takes offsets from data_in
// - offset readback on data_out with load
// - master reset clears pointers, relatches configuration
// - partial reset clears pointers, keeps settings
// - asynchronous flag mode reacts to either side
// - synchronous flags follow count one clock later
// - retransmit rewinds read pointer to start
// - retransmit latency latched at master reset
// - zero latency presents first word immediately
// - byte order picks which half first
// - interspersed parity skips four parity bits
// - non-interspersed ignores top four bits
// - parity placement never touches stored data
// - idle power down, immediate wake up
// - boundary-scan test access port provided
// - standard mode needs explicit read
// - fall-through presents first word automatically
// - low byte_order_sel selects big-endian
// - low parity_placement selects non-interspersed
package flagged_fifo_pkg;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int DEPTH = 1024;
  localparam int ADDR_W = 10;
  localparam int STAGE_DEPTH = 8;
  localparam int OFF_W = 32;
  // parity bit positions in interspersed mode
  localparam int PAR_POS0 = 8;
  localparam int PAR_POS1 = 17;
  localparam int PAR_POS2 = 26;
  localparam int PAR_POS3 = 35;
  // default offsets, indexed by {offset_load_n, sel1, sel0}
  localparam logic [ADDR_W-1:0] DEF_OFFSET [8] = '{
    10'h007, 10'h00f, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff};
  // test access port
  localparam int IR_W = 2;
  localparam logic [IR_W-1:0] IR_IDCODE = 2'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 2'h3;
  localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
  localparam int ID_W = 32;
endpackage : flagged_fifo_pkg

// [logic/flagged_fifo.sv]
`timescale 1ns/1ns
// =====================================================================
// staging buffer
module stage_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  assign in_ready_o = (wp_q - rp_q) != (PW+1)'(DEPTH);
  assign out_valid_o = wp_q != rp_q;
  assign out_data_o = mem[rp_q[PW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (clear_i) begin
      wp_d = '0;
      rp_d = '0;
    end else begin
      if (push) wp_d = wp_q + 1'b1;
      if (pop) rp_d = rp_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !clear_i) mem[wp_q[PW-1:0]] <= in_data_i;
  end
endmodule : stage_fifo

// =====================================================================
// flagged buffer top
module flagged_fifo #(
  parameter int DEPTH = flagged_fifo_pkg::DEPTH,
  parameter int ADDR_W = flagged_fifo_pkg::ADDR_W,
  // arbitrary identification value
  parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // reset controls
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  // configuration sampled during master reset
  input wire logic fall_through_sel_i,
  input wire logic default_offset_sel0_i,
  input wire logic default_offset_sel1_i,
  input wire logic flag_timing_sel_i,
  input wire logic retransmit_latency_sel_i,
  input wire logic byte_order_sel_i,
  input wire logic parity_placement_i,
  input wire logic narrow_out_sel_i,
  // write side
  input wire logic write_enable_n_i,
  input wire logic serial_load_en_n_i,
  input wire logic offset_load_n_i,
  input wire logic [flagged_fifo_pkg::DATA_W-1:0] data_in_i,
  // read side
  input wire logic read_enable_n_i,
  input wire logic retransmit_n_i,
  output logic [flagged_fifo_pkg::DATA_W-1:0] data_out_o,
  // flags
  output logic empty_flag_n_o,
  output logic full_flag_n_o,
  output logic half_full_n_o,
  output logic almost_empty_n_o,
  output logic almost_full_n_o,
  output logic power_down_o,
  // test access port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  import flagged_fifo_pkg::*;

  // =====================================================================
  // reset release
  logic rst_meta_q, rst_b;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b <= rst_meta_q;
    end
  end

  function automatic logic [OFF_W-1:0] offset_bits(input logic [DATA_W-1:0] d, input logic ip);
    logic [OFF_W-1:0] r;
    int k;
    r = '0;
    k = 0;
    for (int i = 0; i < DATA_W; i++) begin
      if (!ip && i < OFF_W) begin
        r[i] = d[i];
      end else if (ip && i != PAR_POS0 && i != PAR_POS1 && i != PAR_POS2 && i != PAR_POS3) begin
        r[k] = d[i];
        k++;
      end
    end
    return r;
  endfunction : offset_bits

  // =====================================================================
  // configuration and offsets
  logic ft_q, ft_d, sync_flag_q, sync_flag_d, rm_q, rm_d, little_q, little_d;
  logic ipar_q, ipar_d, narrow_q, narrow_d, pl_sel_q, pl_sel_d, rb_sel_q, rb_sel_d;
  logic [ADDR_W-1:0] ae_off_q, ae_off_d, af_off_q, af_off_d;
  logic mrst, prst, ptr_clear, ser_load, par_load, rb_req;
  logic [OFF_W-1:0] par_val;

  assign mrst = !master_reset_n_i;
  assign prst = !partial_reset_n_i;
  assign ptr_clear = mrst || prst;
  assign ser_load = !serial_load_en_n_i && !offset_load_n_i;
  assign par_load = !write_enable_n_i && !offset_load_n_i;
  assign rb_req = !read_enable_n_i && !offset_load_n_i;
  assign par_val = offset_bits(data_in_i, ipar_q);

  always_comb begin
    ft_d = ft_q;
    sync_flag_d = sync_flag_q;
    rm_d = rm_q;
    little_d = little_q;
    ipar_d = ipar_q;
    narrow_d = narrow_q;
    ae_off_d = ae_off_q;
    af_off_d = af_off_q;
    pl_sel_d = pl_sel_q;
    rb_sel_d = rb_sel_q;
    if (mrst) begin
      ft_d = fall_through_sel_i;
      sync_flag_d = flag_timing_sel_i;
      rm_d = retransmit_latency_sel_i;
      little_d = byte_order_sel_i;
      ipar_d = parity_placement_i;
      narrow_d = narrow_out_sel_i;
      ae_off_d = DEF_OFFSET[{offset_load_n_i, default_offset_sel1_i, default_offset_sel0_i}];
      af_off_d = DEF_OFFSET[{offset_load_n_i, default_offset_sel1_i, default_offset_sel0_i}];
      pl_sel_d = 1'b0;
      rb_sel_d = 1'b0;
    end else if (prst) begin
      pl_sel_d = 1'b0;
      rb_sel_d = 1'b0;
    end else begin
      if (ser_load) begin
        // serial shift, first bit ends in ae bit 0
        {af_off_d, ae_off_d} = {fall_through_sel_i, af_off_q, ae_off_q[ADDR_W-1:1]};
      end else if (par_load) begin
        if (pl_sel_q) af_off_d = par_val[ADDR_W-1:0];
        else ae_off_d = par_val[ADDR_W-1:0];
        pl_sel_d = !pl_sel_q;
      end
      if (rb_req) rb_sel_d = !rb_sel_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ft_q <= 1'b0;
      sync_flag_q <= 1'b0;
      rm_q <= 1'b0;
      little_q <= 1'b0;
      ipar_q <= 1'b0;
      narrow_q <= 1'b0;
      ae_off_q <= DEF_OFFSET[0];
      af_off_q <= DEF_OFFSET[0];
      pl_sel_q <= 1'b0;
      rb_sel_q <= 1'b0;
    end else begin
      ft_q <= ft_d;
      sync_flag_q <= sync_flag_d;
      rm_q <= rm_d;
      little_q <= little_d;
      ipar_q <= ipar_d;
      narrow_q <= narrow_d;
      ae_off_q <= ae_off_d;
      af_off_q <= af_off_d;
      pl_sel_q <= pl_sel_d;
      rb_sel_q <= rb_sel_d;
    end
  end

  // =====================================================================
  // write path through staging buffer
  logic st_ready, st_valid, mem_full, mem_empty, drain;
  logic [DATA_W-1:0] st_data;
  logic [ADDR_W:0] wptr_q, wptr_d, rptr_q, rptr_d, count;
  logic [DATA_W-1:0] mem [DEPTH];

  // data words bypass all offset handling
  stage_fifo #(.W(DATA_W), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk_i(core_clk_i),
    .rst_b_i(rst_b),
    .clear_i(ptr_clear),
    .in_valid_i(!write_enable_n_i && offset_load_n_i && !ptr_clear),
    .in_data_i(data_in_i),
    .in_ready_o(st_ready),
    .out_valid_o(st_valid),
    .out_data_o(st_data),
    .out_ready_i(!mem_full)
  );

  assign count = wptr_q - rptr_q;
  assign mem_full = count == (ADDR_W+1)'(DEPTH);
  assign mem_empty = count == '0;
  // full memory stalls the drain, staging refuses writes
  assign drain = st_valid && !mem_full && !ptr_clear;

  always_ff @(posedge core_clk_i) begin
    if (drain) mem[wptr_q[ADDR_W-1:0]] <= st_data;
  end

  // =====================================================================
  // read path
  logic out_valid_q, out_valid_d, half_q, half_d, rd_req, present, have_piece, rt;
  logic [DATA_W-1:0] dout_q, dout_d, word, piece, first_word;

  assign rd_req = !read_enable_n_i && offset_load_n_i;
  assign rt = !retransmit_n_i;
  assign word = mem[rptr_q[ADDR_W-1:0]];
  assign first_word = mem[0];
  assign have_piece = half_q || !mem_empty;
  // standard needs a read; fall-through refills itself
  assign present = ft_q ? (!out_valid_q || rd_req) : rd_req;

  // first half chosen by byte order, narrow data in low bits
  always_comb begin
    piece = word;
    if (narrow_q) begin
      if (half_q == little_q) piece = DATA_W'(word[DATA_W-1:HALF_W]);
      else piece = DATA_W'(word[HALF_W-1:0]);
    end
  end

  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    out_valid_d = out_valid_q;
    half_d = half_q;
    dout_d = dout_q;
    if (drain) wptr_d = wptr_q + 1'b1;
    if (ptr_clear) begin
      wptr_d = '0;
      rptr_d = '0;
      out_valid_d = 1'b0;
      half_d = 1'b0;
    end else if (rt) begin
      rptr_d = '0;
      half_d = 1'b0;
      out_valid_d = 1'b0;
      if (!rm_q && wptr_q != '0) begin
        // first word out on the same edge
        out_valid_d = 1'b1;
        if (narrow_q) begin
          dout_d = little_q ? DATA_W'(first_word[HALF_W-1:0]) : DATA_W'(first_word[DATA_W-1:HALF_W]);
          half_d = 1'b1;
        end else begin
          dout_d = first_word;
          rptr_d = (ADDR_W+1)'(1);
        end
      end
    end else if (rb_req) begin
      dout_d = DATA_W'(rb_sel_q ? af_off_q : ae_off_q);
    end else if (present && have_piece) begin
      dout_d = piece;
      out_valid_d = 1'b1;
      if (narrow_q) half_d = !half_q;
      if (!narrow_q || half_q) rptr_d = rptr_q + 1'b1;
    end else if (present && ft_q) begin
      out_valid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= '0;
      rptr_q <= '0;
      out_valid_q <= 1'b0;
      half_q <= 1'b0;
      dout_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      out_valid_q <= out_valid_d;
      half_q <= half_d;
      dout_q <= dout_d;
    end
  end

  assign data_out_o = dout_q;

  // =====================================================================
  // flags
  logic ae_raw, af_raw, ae_q, af_q, hf_q, pd_q, pd_d;

  assign ae_raw = count <= (ADDR_W+1)'(ae_off_q);
  assign af_raw = count >= ((ADDR_W+1)'(DEPTH) - (ADDR_W+1)'(af_off_q));
  // idle when no control input is active
  assign pd_d = write_enable_n_i && read_enable_n_i && serial_load_en_n_i && retransmit_n_i
    && !ptr_clear;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ae_q <= 1'b1;
      af_q <= 1'b0;
      hf_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      ae_q <= ae_raw;
      af_q <= af_raw;
      hf_q <= count > (ADDR_W+1)'(DEPTH / 2);
      pd_q <= pd_d;
    end
  end

  // mode picks empty/full or ready meaning
  // ready flags chain directly to the next buffer
  assign empty_flag_n_o = ft_q ? !out_valid_q : have_piece;
  assign full_flag_n_o = ft_q ? !st_ready : st_ready;
  assign half_full_n_o = !hf_q;
  // one clock here: asynchronous mode follows count at once
  // synchronous mode adds one register stage
  assign almost_empty_n_o = !(sync_flag_q ? ae_q : ae_raw);
  assign almost_full_n_o = !(sync_flag_q ? af_q : af_raw);
  assign power_down_o = pd_q;

  // =====================================================================
  // test access port, tck sampled as an ordinary input
  typedef enum logic [15:0] {
    TRESET = 16'h0001, IDLE = 16'h0002, DR_SEL = 16'h0004, DR_CAP = 16'h0008,
    DR_SH = 16'h0010, DR_EX1 = 16'h0020, DR_PA = 16'h0040, DR_EX2 = 16'h0080,
    DR_UPD = 16'h0100, IR_SEL = 16'h0200, IR_CAP = 16'h0400, IR_SH = 16'h0800,
    IR_EX1 = 16'h1000, IR_PA = 16'h2000, IR_EX2 = 16'h4000, IR_UPD = 16'h8000
  } tap_t;
  tap_t tap_q, tap_d;
  logic tck_q, tck_rise, tck_fall, tdo_q, tdo_d;
  logic [IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
  logic [ID_W-1:0] dr_q, dr_d;

  assign tck_rise = tck_i && !tck_q;
  assign tck_fall = !tck_i && tck_q;

  always_comb begin
    tap_d = tap_q;
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    tdo_d = tdo_q;
    if (!trst_n_i) begin
      tap_d = TRESET;
      ir_d = IR_IDCODE;
    end else if (tck_rise) begin
      case (tap_q)
        TRESET: tap_d = tms_i ? TRESET : IDLE;
        IDLE: tap_d = tms_i ? DR_SEL : IDLE;
        DR_SEL: tap_d = tms_i ? IR_SEL : DR_CAP;
        DR_CAP: tap_d = tms_i ? DR_EX1 : DR_SH;
        DR_SH: tap_d = tms_i ? DR_EX1 : DR_SH;
        DR_EX1: tap_d = tms_i ? DR_UPD : DR_PA;
        DR_PA: tap_d = tms_i ? DR_EX2 : DR_PA;
        DR_EX2: tap_d = tms_i ? DR_UPD : DR_SH;
        DR_UPD: tap_d = tms_i ? DR_SEL : IDLE;
        IR_SEL: tap_d = tms_i ? TRESET : IR_CAP;
        IR_CAP: tap_d = tms_i ? IR_EX1 : IR_SH;
        IR_SH: tap_d = tms_i ? IR_EX1 : IR_SH;
        IR_EX1: tap_d = tms_i ? IR_UPD : IR_PA;
        IR_PA: tap_d = tms_i ? IR_EX2 : IR_PA;
        IR_EX2: tap_d = tms_i ? IR_UPD : IR_SH;
        IR_UPD: tap_d = tms_i ? DR_SEL : IDLE;
        default: tap_d = TRESET;
      endcase
      case (tap_q)
        TRESET: ir_d = IR_IDCODE;
        DR_CAP: dr_d = (ir_q == IR_IDCODE) ? ID_CODE : '0;
        DR_SH: begin
          if (ir_q == IR_IDCODE) dr_d = {tdi_i, dr_q[ID_W-1:1]};
          else dr_d = {{(ID_W-1){1'b0}}, tdi_i};
        end
        IR_CAP: irs_d = IR_CAPTURE;
        IR_SH: irs_d = {tdi_i, irs_q[IR_W-1:1]};
        IR_UPD: ir_d = irs_q;
        default: ;
      endcase
    end else if (tck_fall) begin
      // data leaves on the falling edge
      tdo_d = (tap_q == IR_SH) ? irs_q[0] : dr_q[0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      tap_q <= TRESET;
      tck_q <= 1'b0;
      ir_q <= IR_IDCODE;
      irs_q <= '0;
      dr_q <= '0;
      tdo_q <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tap_q <= tap_d;
      tck_q <= tck_i;
      ir_q <= ir_d;
      irs_q <= irs_d;
      dr_q <= dr_d;
      tdo_q <= tdo_d;
      if (tck_fall) tdo_oe_o <= (tap_q == DR_SH) || (tap_q == IR_SH);
    end
  end

  assign tdo_o = tdo_q;
endmodule : flagged_fifo

// [test/stream_writer.sv]
`timescale 1ns/1ns
// =====================================================================
// writing controller model
module stream_writer (
  // clock
  input wire logic clk_i,
  // bench control
  input wire logic go_i,
  input wire logic [15:0] limit_i,
  input wire logic [35:0] base_i,
  input wire logic fall_through_mode_i,
  // buffer side
  input wire logic full_flag_n_i,
  output logic write_enable_n_o,
  output logic [35:0] data_o,
  output logic [15:0] sent_o
);
  logic ready;
  assign ready = fall_through_mode_i ? !full_flag_n_i : full_flag_n_i;
  initial begin
    write_enable_n_o = 1'b1;
    data_o = 36'h0;
    sent_o = 16'h0;
  end
  // count only words the buffer took
  always @(posedge clk_i) begin
    if (!go_i) sent_o <= 16'h0;
    else if (!write_enable_n_o && ready) sent_o <= sent_o + 16'h1;
  end
  // request held until taken; idle data keeps moving
  always @(negedge clk_i) begin
    write_enable_n_o <= !(go_i && sent_o < limit_i);
    data_o <= (go_i && sent_o < limit_i) ? base_i + 36'(sent_o) : ~data_o;
  end
endmodule : stream_writer

// [test/flagged_fifo_sva.sv]
`timescale 1ns/1ns
// =====================================================================
// port checker
module flagged_fifo_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // controls
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire logic fall_through_sel_i,
  input wire logic flag_timing_sel_i,
  input wire logic write_enable_n_i,
  input wire logic serial_load_en_n_i,
  input wire logic offset_load_n_i,
  input wire logic read_enable_n_i,
  input wire logic retransmit_n_i,
  // outputs
  input wire logic [flagged_fifo_pkg::DATA_W-1:0] data_out_o,
  input wire logic empty_flag_n_o,
  input wire logic full_flag_n_o,
  input wire logic half_full_n_o,
  input wire logic almost_empty_n_o,
  input wire logic almost_full_n_o,
  input wire logic power_down_o
);
  logic fall_through_mode_q, fall_through_mode_d, sync_q, sync_d, std_async, cause, idle;
  // mode copy latched the same way as the block
  always_comb begin
    fall_through_mode_d = master_reset_n_i ? fall_through_mode_q : fall_through_sel_i;
    sync_d = master_reset_n_i ? sync_q : flag_timing_sel_i;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fall_through_mode_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      fall_through_mode_q <= fall_through_mode_d;
      sync_q <= sync_d;
    end
  end
  assign std_async = !fall_through_mode_q && !sync_q;
  assign cause = !read_enable_n_i || !retransmit_n_i || !master_reset_n_i || !partial_reset_n_i;
  assign idle = write_enable_n_i && read_enable_n_i && serial_load_en_n_i && retransmit_n_i
    && master_reset_n_i && partial_reset_n_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // =====================================================================
  // properties
  pwr_wake_a: assert property ((!read_enable_n_i || !write_enable_n_i) |=> !power_down_o)
    else $error("power down while busy");
  // five idle cycles cover the reset synchroniser delay
  pwr_idle_a: assert property (idle [*5] |-> power_down_o)
    else $error("no power down when idle");
  mr_clear_a: assert property ((!master_reset_n_i && !fall_through_sel_i) |=> (!empty_flag_n_o && full_flag_n_o))
    else $error("master reset left data");
  pr_clear_a: assert property ((!partial_reset_n_i && master_reset_n_i && !fall_through_mode_q) |=> !empty_flag_n_o)
    else $error("partial reset left data");
  empty_read_a: assert property ((!fall_through_mode_q && !empty_flag_n_o && !read_enable_n_i && offset_load_n_i
    && retransmit_n_i && master_reset_n_i && partial_reset_n_i) |=> $stable(data_out_o))
    else $error("read taken while empty");
  data_hold_a: assert property ((!fall_through_mode_q && $changed(data_out_o)) |-> $past(cause))
    else $error("output moved without read");
  ae_empty_a: assert property ((std_async && !empty_flag_n_o) |-> !almost_empty_n_o)
    else $error("almost empty high while empty");
  full_flags_a: assert property ((std_async && !full_flag_n_o) |-> (!almost_full_n_o && !half_full_n_o))
    else $error("full without half or almost full");
  half_data_a: assert property ((!fall_through_mode_q && !half_full_n_o && $past(master_reset_n_i)
    && $past(partial_reset_n_i)) |-> empty_flag_n_o)
    else $error("half full while empty");
  full_seen_c: cover property (!full_flag_n_o);
  retx_seen_c: cover property (!retransmit_n_i && master_reset_n_i);
  readback_seen_c: cover property (!read_enable_n_i && !offset_load_n_i);
endmodule : flagged_fifo_sva

bind flagged_fifo flagged_fifo_sva u_flagged_fifo_sva (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .master_reset_n_i(master_reset_n_i),
  .partial_reset_n_i(partial_reset_n_i), .fall_through_sel_i(fall_through_sel_i),
  .flag_timing_sel_i(flag_timing_sel_i), .write_enable_n_i(write_enable_n_i),
  .serial_load_en_n_i(serial_load_en_n_i), .offset_load_n_i(offset_load_n_i),
  .read_enable_n_i(read_enable_n_i), .retransmit_n_i(retransmit_n_i), .data_out_o(data_out_o),
  .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o), .half_full_n_o(half_full_n_o),
  .almost_empty_n_o(almost_empty_n_o), .almost_full_n_o(almost_full_n_o), .power_down_o(power_down_o)
);

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
  import flagged_fifo_pkg::*;
  logic core_clk_i, rst_b_i, mrst_n, prst_n, ft_sel, osel0, osel1, sync_sel, rlat_sel;
  logic order_sel, par_sel, narrow_sel, tb_wen_n, ser_en_n, load_n, ren_n, retx_n;
  logic empty_n, full_n, half_n, aempty_n, afull_n, pdown, pw_go, pw_wen_n, wen_n, ft_mode;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [35:0] tb_din, pw_base, pw_d, din, dout;
  logic [15:0] pw_lim, pw_sent;
  int mismatches = 0;
  int samples_checked = 0;
  assign wen_n = tb_wen_n & pw_wen_n;
  assign din = tb_wen_n ? pw_d : tb_din;
  flagged_fifo u_flagged_fifo (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .master_reset_n_i(mrst_n), .partial_reset_n_i(prst_n),
    .fall_through_sel_i(ft_sel), .default_offset_sel0_i(osel0), .default_offset_sel1_i(osel1),
    .flag_timing_sel_i(sync_sel), .retransmit_latency_sel_i(rlat_sel), .byte_order_sel_i(order_sel),
    .parity_placement_i(par_sel), .narrow_out_sel_i(narrow_sel), .write_enable_n_i(wen_n),
    .serial_load_en_n_i(ser_en_n), .offset_load_n_i(load_n), .data_in_i(din), .read_enable_n_i(ren_n),
    .retransmit_n_i(retx_n), .data_out_o(dout), .empty_flag_n_o(empty_n), .full_flag_n_o(full_n),
    .half_full_n_o(half_n), .almost_empty_n_o(aempty_n), .almost_full_n_o(afull_n), .power_down_o(pdown),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(rst_b_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe)
  );
  stream_writer u_stream_writer (
    .clk_i(core_clk_i), .go_i(pw_go), .limit_i(pw_lim), .base_i(pw_base), .fall_through_mode_i(ft_mode),
    .full_flag_n_i(full_n), .write_enable_n_o(pw_wen_n), .data_o(pw_d), .sent_o(pw_sent)
  );
  // =====================================================================
  // helpers
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // bits: sync, fall-through, latency, order, parity, narrow, then default index
  task automatic cfg(input logic [8:0] c);
    {sync_sel, ft_sel, rlat_sel, order_sel, par_sel, narrow_sel, load_n, osel1, osel0} = c;
    ft_mode = c[7];
    mrst_n = 1'b0;
    cyc(2);
    mrst_n = 1'b1;
    ft_sel = 1'b0;
    load_n = 1'b1;
    cyc(1);
  endtask : cfg
  task automatic readback(input logic [9:0] ae, input logic [9:0] af);
    load_n = 1'b0;
    ren_n = 1'b0;
    cyc(1);
    chk("ae offset", dout, 36'(ae));
    cyc(1);
    chk("af offset", dout, 36'(af));
    ren_n = 1'b1;
    load_n = 1'b1;
    cyc(1);
  endtask : readback
  task automatic rd(input logic [35:0] exp, input bit half);
    for (int i = 0; i < 20 && empty_n !== 1'b1; i++) cyc(1);
    ren_n = 1'b0;
    cyc(1);
    ren_n = 1'b1;
    chk("read word", half ? 36'(dout[17:0]) : dout, exp);
    cyc(1);
  endtask : rd
  task automatic wr(input int n, input logic [35:0] b);
    pw_base = b;
    pw_lim = 16'(n);
    pw_go = 1'b1;
    for (int i = 0; i < 4000 && pw_sent !== 16'(n); i++) cyc(1);
    pw_go = 1'b0;
    cyc(1);
  endtask : wr
  function automatic logic [9:0] off(input logic [35:0] d, input bit p);
    return p ? {d[10:9], d[7:0]} : d[9:0];
  endfunction : off
  // =====================================================================
  // scenarios
  task automatic t_defaults;
    for (int i = 0; i < 8; i++) begin
      cfg(9'(i));
      chk("empty flag", 36'(empty_n), 36'h0);
      chk("full flag", 36'(full_n), 36'h1);
      readback(DEF_OFFSET[i], DEF_OFFSET[i]);
    end
  endtask : t_defaults
  task automatic t_parallel;
    logic [35:0] v [2];
    v = '{36'h0_0000_0155, 36'hf_0000_02aa};
    for (int p = 0; p < 2; p++) begin
      cfg({4'h0, 1'(p), 4'h0});
      load_n = 1'b0;
      tb_wen_n = 1'b0;
      tb_din = v[0];
      cyc(1);
      tb_din = v[1];
      cyc(1);
      tb_wen_n = 1'b1;
      load_n = 1'b1;
      cyc(1);
      readback(off(v[0], 1'(p)), off(v[1], 1'(p)));
      wr(1, 36'h8_0402_0100);
      rd(36'h8_0402_0100, 1'b0);
    end
  endtask : t_parallel
  task automatic t_serial;
    logic [19:0] v;
    v = {10'h13a, 10'h2c5};
    load_n = 1'b0;
    ser_en_n = 1'b0;
    for (int k = 0; k < 20; k++) begin
      ft_sel = v[k];
      cyc(1);
    end
    ser_en_n = 1'b1;
    load_n = 1'b1;
    ft_sel = 1'b0;
    cyc(1);
    readback(10'h2c5, 10'h13a);
  endtask : t_serial
  task automatic t_fill;
    cfg(9'h000);
    wr(DEPTH + STAGE_DEPTH, 36'h0);
    chk("full flag", 36'(full_n), 36'h0);
    chk("half flag", 36'(half_n), 36'h0);
    chk("afull flag", 36'(afull_n), 36'h0);
    tb_din = 36'h5_5555_5555;
    tb_wen_n = 1'b0;
    cyc(1);
    tb_wen_n = 1'b1;
    for (int k = 0; k < DEPTH + STAGE_DEPTH; k++) rd(36'(k), 1'b0);
    ren_n = 1'b0;
    cyc(1);
    ren_n = 1'b1;
    cyc(1);
    chk("empty read", dout, 36'(DEPTH + STAGE_DEPTH - 1));
    chk("aempty flag", 36'(aempty_n), 36'h0);
  endtask : t_fill
  task automatic t_retx;
    for (int r = 0; r < 2; r++) begin
      cfg({2'h0, 1'(r), 6'h05});
      wr(3, 36'h100);
      rd(36'h100, 1'b0);
      rd(36'h101, 1'b0);
      retx_n = 1'b0;
      cyc(1);
      retx_n = 1'b1;
      if (r == 0) chk("zero latency", dout, 36'h100);
      else rd(36'h100, 1'b0);
      rd(36'h101, 1'b0);
      prst_n = 1'b0;
      cyc(1);
      prst_n = 1'b1;
      cyc(1);
      chk("empty flag", 36'(empty_n), 36'h0);
      readback(DEF_OFFSET[5], DEF_OFFSET[5]);
    end
  endtask : t_retx
  task automatic t_narrow;
    logic [35:0] w;
    w = 36'h9_1234_5678;
    for (int b = 0; b < 2; b++) begin
      cfg({3'h0, 1'(b), 1'h0, 1'h1, 3'h0});
      wr(1, w);
      rd(b ? 36'(w[17:0]) : 36'(w[35:18]), 1'b1);
      rd(b ? 36'(w[35:18]) : 36'(w[17:0]), 1'b1);
    end
  endtask : t_narrow
  task automatic t_fall_through_mode;
    cfg(9'h180);
    wr(2, 36'h200);
    for (int i = 0; i < 20 && empty_n !== 1'b0; i++) cyc(1);
    chk("first word", dout, 36'h200);
    cyc(3);
    chk("held word", dout, 36'h200);
    ren_n = 1'b0;
    cyc(1);
    ren_n = 1'b1;
    cyc(2);
    chk("next word", dout, 36'h201);
    cyc(2);
    chk("power down", 36'(pdown), 36'h1);
  endtask : t_fall_through_mode
  // scan clock four core cycles long, walks into instruction shift
  task automatic t_tap;
    logic [2:0] e;
    e = {1'b1, IR_CAPTURE};
    tdi = 1'b1;
    for (int k = 0; k < 7; k++) begin
      tms = k == 1 || k == 2;
      tck = 1'b1;
      cyc(2);
      tck = 1'b0;
      cyc(2);
      if (k > 3) chk("scan out", 36'(tdo), 36'(e[k-4]));
    end
    chk("scan enable", 36'(tdo_oe), 36'h1);
  endtask : t_tap
  // =====================================================================
  // run
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    {tdi, tms, tck, rst_b_i, mrst_n, prst_n, ft_sel, osel0, osel1, sync_sel, rlat_sel, order_sel, par_sel,
      narrow_sel} = 14'h1300;
    {tb_wen_n, ser_en_n, load_n, ren_n, retx_n, pw_go, ft_mode} = 7'h7c;
    tb_din = 36'h0;
    pw_base = 36'h0;
    pw_lim = 16'h0;
    cyc(2);
    rst_b_i = 1'b1;
    cyc(3);
    t_defaults();
    t_parallel();
    t_serial();
    t_fill();
    t_retx();
    t_narrow();
    t_fall_through_mode();
    t_tap();
    end_sim();
  end
  // run needs about 3300 cycles
  initial begin
    #1_000_000;
    mismatches++;
    end_sim();
  end
endmodule : tb
